/* bench/code_source.sv */
// Purpose: far-side model of the code source, resolving each shared pin
// Assumes: device drive wins wherever its enable is high
// Notes:   released lines show the far side's own level, never the device's last value
`timescale 1ns/1ps
module code_source (
  // levels the far side presents
  input  wire logic [5:0] want_lvl,
  // device drive
  input  wire logic [5:0] dev_out,
  input  wire logic [5:0] dev_oe,
  // resolved pins
  output logic      [5:0] pin_lvl
);
  always_comb begin
    pin_lvl = (dev_oe & dev_out) | (~dev_oe & want_lvl);
  end
endmodule

/* bench/testbench.sv */
// Purpose: self-checking bench for the code-input and general pin block
// Assumes: history window shortened to 8 cycles
// Notes:   expected bytes come from a small integer model of the registers
`timescale 1ns/1ps
module testbench;
  import id_code_and_gpio_pkg::*;
  localparam int HIST = 8;
  logic       ref_clk   = 1'b0;
  logic       rst_n     = 1'b0;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic [7:0] reg_addr  = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [5:0] drive_lvl = 6'h00;
  logic       sup_bad   = 1'b0;
  logic [7:0] reg_rdata, rd;
  logic [5:0] pin_wire, pin_out, pin_oe;
  logic       thr_sel, func_sel, alert_n, seen;
  int         mismatches = 0;
  int         checked    = 0;
  int         m_func = 0, m_thr = 0, m_lvl = 0, m_cfg5 = 0;

  always #50 ref_clk = ~ref_clk;

  vid_input_change_detect_gpio #(.HIST_CYCLES(HIST)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .code_pin_in(pin_wire), .code_pin_out(pin_out), .code_pin_oe(pin_oe),
    .supply_out_of_limit(sup_bad), .code_threshold_select(thr_sel),
    .shared_pin_function_select(func_sel), .alert_n(alert_n));
  code_source i_src (.want_lvl(drive_lvl), .dev_out(pin_out), .dev_oe(pin_oe),
    .pin_lvl(pin_wire));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // pin six follows its own field, and turns output with the others while it is a code input
  function automatic logic [5:0] exp_oe();
    logic six;
    six = (m_cfg5[3:2] == 2'h1) || (m_cfg5[4] && m_func[0]);
    return {six, {5{m_cfg5[4]}}};
  endfunction
  function automatic logic [7:0] exp43();
    logic [5:0] w;
    w = (exp_oe() & 6'(m_lvl)) | (~exp_oe() & drive_lvl);
    return {m_func[0], m_thr[0], m_func[0] & w[5], w[4:0]};
  endfunction
  // drain the flag: two reads, the second must find it clear
  task automatic flag_check(input string what, input logic [7:0] exp);
    rdreg(OFS_INT_STATUS_TWO, rd);
    chk(what, exp, rd);
    rdreg(OFS_INT_STATUS_TWO, rd);
    chk("flag cleared", 8'h00, rd);
  endtask

  initial begin : watchdog
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end

  initial begin : main
    void'($urandom(95));
    repeat (8) @(posedge ref_clk);
    rst_n     <= 1'b1;
    drive_lvl <= 6'($urandom());
    repeat (4) @(posedge ref_clk);
    chk("alert", 8'h01, {7'h0, alert_n});
    chk("oe", 8'h00, {2'h0, pin_oe});
    rdreg(OFS_ID_CODE_GPIO, rd);
    chk("id code", exp43(), rd);
    rdreg(8'h55, rd);
    chk("unmapped", 8'h00, rd);
    for (int k = 0; k < 4; k++) begin
      m_thr  = k & 1;
      m_func = k >> 1;
      wr(OFS_ID_CODE_GPIO, {m_func[0], m_thr[0], 6'h00});
      drive_lvl <= 6'($urandom());
      repeat (4) @(posedge ref_clk);
      chk("threshold", {7'h0, m_thr[0]}, {7'h0, thr_sel});
      chk("function", {7'h0, m_func[0]}, {7'h0, func_sel});
      rdreg(OFS_ID_CODE_GPIO, rd);
      chk("id code", exp43(), rd);
    end
    // a supply fault while in code mode must not reach the shared flag
    sup_bad <= 1'b1;
    repeat (3 * HIST) @(posedge ref_clk);
    sup_bad <= 1'b0;
    rdreg(OFS_INT_STATUS_TWO, rd);
    flag_check("steady flag", 8'h00);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_INT_MASK_TWO, 8'(m));
      rdreg(OFS_INT_MASK_TWO, rd);
      chk("mask", 8'(m), rd);
      drive_lvl <= drive_lvl ^ 6'(1 << ($urandom() % 6));
      seen = 1'b0;
      repeat (3 * HIST) begin
        @(posedge ref_clk);
        if (alert_n === 1'b0) seen = 1'b1;
      end
      chk("alert seen", 8'(1 - m), {7'h0, seen});
      flag_check("change flag", 8'h01);
      chk("alert released", 8'h01, {7'h0, alert_n});
    end
    m_func = 0;
    wr(OFS_ID_CODE_GPIO, {1'b0, m_thr[0], 6'h00});
    sup_bad <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sup_bad <= 1'b0;
    flag_check("supply flag", 8'h01);
    m_func = 1;
    m_thr  = 1;
    for (int k = 0; k < 5; k++) begin
      m_lvl  = $urandom() & 63;
      m_cfg5 = (k < 4) ? (16 | (k << 2)) : 0;
      wr(OFS_ID_CODE_GPIO, {2'b11, 6'(m_lvl)});
      wr(OFS_CONFIG_FIVE, 8'(m_cfg5));
      drive_lvl <= ~6'(m_lvl);
      repeat (4) @(posedge ref_clk);
      chk("oe", {2'h0, exp_oe()}, {2'h0, pin_oe});
      chk("out", {2'h0, exp_oe() & 6'(m_lvl)}, {2'h0, pin_oe & pin_out});
      rdreg(OFS_ID_CODE_GPIO, rd);
      chk("id code", exp43(), rd);
      rdreg(OFS_CONFIG_FIVE, rd);
      chk("config five", 8'(m_cfg5), rd);
    end
    final_report();
  end
endmodule

/* core/code_sync.sv */
// Purpose: two-flop synchroniser for a bus of asynchronous pins
// Assumes: single clock, asynchronous active-low reset
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module code_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

/* core/id_code_and_gpio_pkg.sv */
// Purpose: constants for the identification-code input and general-purpose pin block
// Assumes: 10 MHz ref_clk, registers reached through a simple byte-wide port
// Notes:   offsets are the printed register addresses
package id_code_and_gpio_pkg;
  localparam logic [7:0] OFS_INT_STATUS_TWO = 8'h42;
  localparam logic [7:0] OFS_ID_CODE_GPIO   = 8'h43;
  localparam logic [7:0] OFS_INT_MASK_TWO   = 8'h75;
  localparam logic [7:0] OFS_CONFIG_FIVE    = 8'h7c;
  // field positions
  localparam int BIT_THRESHOLD   = 6;
  localparam int BIT_PIN_FUNC    = 7;
  localparam int BIT_SIXTH_CODE  = 5;
  localparam int BIT_FLAG        = 0;
  localparam int BIT_GPIO_EN     = 4;
  localparam int BIT_PIN_SIX_LO  = 2;
  // pin-six field encodings
  localparam logic [1:0] PIN_SIX_INPUT  = 2'h0;
  localparam logic [1:0] PIN_SIX_OUTPUT = 2'h1;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // history window
  localparam int CLK_PERIOD_NS   = 100;
  localparam int HISTORY_NS      = 11000;
  localparam int HISTORY_CYCLES  = HISTORY_NS / CLK_PERIOD_NS;
  localparam int CODE_WIDTH      = 6;
endpackage

/* core/vid_input_change_detect_gpio.sv */
// Purpose: identification-code inputs, shared pin select, change detect, alert, GPIO mode
// Assumes: registers reached through a simple byte-wide read/write port, one access per cycle
// Notes:   status flag cleared by reading it; set wins over the read clear
//
// Notes on behaviour
// - a register bit picks the code-input threshold, nominal when clear and reduced when set.
// - a register bit makes the shared pin a supply input when clear or the sixth code input when set.
// - in supply mode the sixth code bit always reads zero.
// - in supply mode the shared status bit reports supply out-of-limit results.
// - in code mode the sixth code bit shows the shared pin's present level, or its written level while GPIO is enabled.
// - in code mode code changes are detected and reported in the shared status bit.
// - the change flag sets when present code levels differ from those 11 us earlier.
// - a detected code change raises the alert unless masked.
// - the mask bit suppresses the alert while the change is still recorded.
// - the GPIO enable bit turns every pin used as a code input into an output.
// - each output drives the level software last wrote to its code bit.
// - general pin six is configured on its own through a two-bit field.
// - general pins are numbered zero to four and six with no pin five.
// - bits zero to four show the five dedicated code input levels, or their written levels while GPIO is enabled.
`timescale 1ns/1ps
module vid_input_change_detect_gpio
  import id_code_and_gpio_pkg::*;
#(
  parameter int HIST_CYCLES = HISTORY_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // code pins 0..4 and shared pin (index 5 = pin six)
  input  wire logic [5:0] code_pin_in,
  output logic      [5:0] code_pin_out,
  output logic      [5:0] code_pin_oe,
  // analog front end hooks
  input  wire logic       supply_out_of_limit,
  output logic            code_threshold_select,
  output logic            shared_pin_function_select,
  // alert, active low
  output logic            alert_n
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ARMED = 2'b10
  } hist_state_type;

  logic [5:0]  code_sync;
  logic [7:0]  code_reg_ff, nxt_code_reg;
  logic        mask_ff, nxt_mask;
  logic [7:0]  cfg5_ff, nxt_cfg5;
  logic        flag_ff, nxt_flag;
  logic [5:0]  hist_ff, nxt_hist;
  logic [15:0] cnt_ff, nxt_cnt;
  hist_state_type st_ff, nxt_st;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic [5:0]  live_mask;
  logic        code_mode, gpio_en, change_evt, rd_status;
  logic [7:0]  code_view;

  code_sync #(.WIDTH(CODE_WIDTH)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (code_pin_in),
    .sync_out (code_sync)
  );

  assign code_mode = code_reg_ff[BIT_PIN_FUNC];
  assign gpio_en   = cfg5_ff[BIT_GPIO_EN];
  assign code_threshold_select      = code_reg_ff[BIT_THRESHOLD];
  assign shared_pin_function_select = code_mode;
  // pins 0..4 always take part in the comparison, even as GPIO outputs; the shared pin only in code mode
  assign live_mask = {code_mode, 5'h1f};
  assign change_evt = (st_ff == ST_ARMED) && (cnt_ff == 16'(HIST_CYCLES - 1))
                      && (((code_sync ^ hist_ff) & live_mask) != 6'h00);
  assign rd_status = reg_rd && (reg_addr == OFS_INT_STATUS_TWO);

  // history snapshot every window; compared against present levels at window end
  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_hist = hist_ff;
    case (st_ff)
      ST_IDLE: begin
        nxt_hist = code_sync;
        nxt_cnt  = 16'h0000;
        nxt_st   = ST_ARMED;
      end
      ST_ARMED: begin
        if (cnt_ff == 16'(HIST_CYCLES - 1)) begin
          nxt_hist = code_sync;
          nxt_cnt  = 16'h0000;
        end else begin
          nxt_cnt = cnt_ff + 16'h0001;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  // shared flag: change in code mode, supply limit otherwise; set beats read clear
  always_comb begin
    nxt_flag = flag_ff;
    if (rd_status) nxt_flag = 1'b0;
    if (code_mode && change_evt) nxt_flag = 1'b1;
    if (!code_mode && supply_out_of_limit) nxt_flag = 1'b1;
  end

  always_comb begin
    nxt_code_reg = code_reg_ff;
    nxt_mask     = mask_ff;
    nxt_cfg5     = cfg5_ff;
    if (reg_wr) begin
      if (reg_addr == OFS_ID_CODE_GPIO) begin
        nxt_code_reg = reg_wdata;
      end else if (reg_addr == OFS_INT_MASK_TWO) begin
        nxt_mask = reg_wdata[BIT_FLAG];
      end else if (reg_addr == OFS_CONFIG_FIVE) begin
        nxt_cfg5 = reg_wdata;
      end
    end
  end

  always_comb begin
    // in GPIO mode bits show the driven levels, else live pin levels
    code_view = {code_reg_ff[7:6], 6'h00};
    code_view[4:0] = gpio_en ? code_reg_ff[4:0] : code_sync[4:0];
    if (code_mode) begin
      code_view[BIT_SIXTH_CODE] = gpio_en ? code_reg_ff[BIT_SIXTH_CODE]
                                          : code_sync[BIT_SIXTH_CODE];
    end else begin
      code_view[BIT_SIXTH_CODE] = 1'b0;
    end
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == OFS_INT_STATUS_TWO) begin
        nxt_rdata = {7'h00, flag_ff};
      end else if (reg_addr == OFS_ID_CODE_GPIO) begin
        nxt_rdata = code_view;
      end else if (reg_addr == OFS_INT_MASK_TWO) begin
        nxt_rdata = {7'h00, mask_ff};
      end else if (reg_addr == OFS_CONFIG_FIVE) begin
        nxt_rdata = cfg5_ff;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg_ff <= RESET_BYTE;
      mask_ff     <= 1'b0;
      cfg5_ff     <= RESET_BYTE;
      flag_ff     <= 1'b0;
      hist_ff     <= 6'h00;
      cnt_ff      <= 16'h0000;
      st_ff       <= ST_IDLE;
      rdata_ff    <= RESET_BYTE;
    end else begin
      code_reg_ff <= nxt_code_reg;
      mask_ff     <= nxt_mask;
      cfg5_ff     <= nxt_cfg5;
      flag_ff     <= nxt_flag;
      hist_ff     <= nxt_hist;
      cnt_ff      <= nxt_cnt;
      st_ff       <= nxt_st;
      rdata_ff    <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  // alert from the recorded flag; mask gates only the alert
  assign alert_n = !(flag_ff && !mask_ff);

  // pins 0..4 become outputs when GPIO enabled; pin six (index 5) has its own field
  always_comb begin
    code_pin_out = {1'b0, code_reg_ff[4:0]};
    code_pin_oe  = {1'b0, {5{gpio_en}}};
    if (cfg5_ff[BIT_PIN_SIX_LO +: 2] == PIN_SIX_OUTPUT) begin
      code_pin_oe[5]  = 1'b1;
      code_pin_out[5] = code_reg_ff[BIT_SIXTH_CODE];
    end else if (gpio_en && code_mode) begin
      code_pin_oe[5]  = 1'b1;
      code_pin_out[5] = code_reg_ff[BIT_SIXTH_CODE];
    end
  end

  sequence s_window_end_diff;
    (st_ff == ST_ARMED) && (cnt_ff == 16'(HIST_CYCLES - 1)) && code_mode
      && (((code_sync ^ hist_ff) & live_mask) != 6'h00);
  endsequence

  AST_CHANGE_SETS_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_window_end_diff |=> flag_ff) else $error("code change not flagged");
  AST_ALERT_UNMASKED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_window_end_diff and !mask_ff) |=> (!alert_n || $changed(mask_ff)))
    else $error("alert missing");
  AST_MASK_BLOCKS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mask_ff |-> alert_n) else $error("masked alert fired");
  AST_THRESH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == OFS_ID_CODE_GPIO)
      |=> code_threshold_select == $past(reg_wdata[BIT_THRESHOLD]))
    else $error("threshold bit wrong");
  AST_SIXTH_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_ID_CODE_GPIO && !code_mode) |=> reg_rdata[5] == 1'b0)
    else $error("sixth bit not zero");
  AST_SUPPLY_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!code_mode && supply_out_of_limit) |=> flag_ff) else $error("supply flag lost");
  AST_GPIO_OE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gpio_en |-> (code_pin_oe[4:0] == 5'h1f && code_pin_out[4:0] == code_reg_ff[4:0]))
    else $error("gpio outputs wrong");
  AST_INPUT_VIEW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_ID_CODE_GPIO && !gpio_en)
      |=> reg_rdata[4:0] == $past(code_sync[4:0]))
    else $error("code bits mismatch");
  AST_NO_FALSE_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (code_mode && !flag_ff && !change_evt) |=> !flag_ff) else $error("spurious flag");
endmodule
